//--- rtl/phygs_pkg.sv
package phygs_pkg;

  // Bit positions within the generic status word.
  localparam int unsigned BIT_ABIL_HI   = 14;
  localparam int unsigned BIT_ABIL_LO   = 11;
  localparam int unsigned BIT_RSVD_HI   = 10;
  localparam int unsigned BIT_RSVD_LO   = 7;
  localparam int unsigned BIT_PRE_SUPP  = 6;
  localparam int unsigned BIT_NEG_CMPLT = 5;
  localparam int unsigned BIT_REMOTE_FAULT_FLAG    = 4;
  localparam int unsigned BIT_NEG_ABIL  = 3;
  localparam int unsigned BIT_LINK      = 2;
  localparam int unsigned BIT_JABBER    = 1;

  localparam logic [15:0] STATUS_RESET  = 16'h7800;
  localparam logic        LINK_RESET    = 1'b1;
  localparam logic        REMOTE_FAULT_FLAG_RESET  = 1'b0;
  localparam logic        JABBER_RESET  = 1'b0;

  // Times in their own units, then clock counts derived from the rate.
  localparam longint unsigned CLK_HZ     = 64'd50_000_000;
  localparam longint unsigned GAP_MIN_MS = 64'd8;
  localparam longint unsigned GAP_MAX_MS = 64'd24;
  localparam longint unsigned FAIL_MS    = 64'd100;
  localparam longint unsigned LOCK_US    = 64'd330;

  localparam int unsigned GAP_MIN_CYC = int'((GAP_MIN_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam int unsigned GAP_MAX_CYC = int'((GAP_MAX_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned FAIL_CYC    = int'((FAIL_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned LOCK_CYC    = int'((LOCK_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  localparam int unsigned RUN_LEN     = 7;

  // Signals from the negotiation engine and control register.
  typedef struct packed {
    logic enable;
    logic restart;
    logic done;
    logic err_restart;
  } phygs_neg_t;

endpackage

//--- rtl/phygs_lock_qual.sv
`timescale 1ns/100ps
module phygs_lock_qual
  import phygs_pkg::*;
#(
  parameter int unsigned LOCK_N = LOCK_CYC
) (
  input  wire logic sys_clk_i,   // Device clock.
  input  wire logic nrst_i,      // Synchronous reset, active low.
  input  wire logic lock_i,      // Descrambler lock level.
  output logic      lock_ok_o    // Lock held long enough.
);

  localparam int unsigned CW = $clog2(LOCK_N + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // Any drop of lock restarts the qualification time.
  always_comb begin
    next_cnt = cnt;
    if (!lock_i) begin
      next_cnt = '0;
    end else if (cnt != CW'(LOCK_N)) begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign lock_ok_o = (cnt == CW'(LOCK_N));  // see R14

  a_lock_drop_clears: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R14
    !lock_i |=> !lock_ok_o) else $error("Lock qualified right after lock loss.");

endmodule

//--- rtl/phygs_pulse_mon.sv
`timescale 1ns/100ps
module phygs_pulse_mon
  import phygs_pkg::*;
#(
  parameter int unsigned MIN_N  = GAP_MIN_CYC,
  parameter int unsigned MAX_N  = GAP_MAX_CYC,
  parameter int unsigned FAIL_N = FAIL_CYC,
  parameter int unsigned RUN_N  = RUN_LEN
) (
  input  wire logic sys_clk_i,     // Device clock.
  input  wire logic nrst_i,        // Synchronous reset, active low.
  input  wire logic pulse_pin_i,   // Link pulse from the line, asynchronous.
  input  wire logic neg_enable_i,  // Negotiation switched on.
  input  wire logic neg_done_i,    // Negotiation finished.
  output logic      link_ok_o      // Link-integrity verdict.
);

  localparam int unsigned CW = $clog2(FAIL_N + 2);
  localparam int unsigned RW = $clog2(RUN_N + 1);

  typedef enum logic [1:0] {
    PHYGS_FAIL = 2'b01,
    PHYGS_GOOD = 2'b10
  } phygs_lnk_t;

  logic [2:0]    sync;
  logic [CW-1:0] gap;
  logic [CW-1:0] next_gap;
  logic [RW-1:0] run;
  logic [RW-1:0] next_run;
  phygs_lnk_t    state;
  phygs_lnk_t    next_state;
  logic          edge_seen;
  logic          gap_good;

  assign edge_seen = sync[1] & ~sync[2];
  assign gap_good  = (gap >= CW'(MIN_N)) && (gap <= CW'(MAX_N));  // see R11

  always_comb begin
    next_gap   = gap;
    next_run   = run;
    next_state = state;
    if (edge_seen) begin
      next_gap = '0;
      if (!gap_good) begin
        next_run = '0;
      end else if (run != RW'(RUN_N)) begin
        next_run = run + RW'(1);  // see R18
      end
    end else if (gap <= CW'(FAIL_N)) begin
      next_gap = gap + CW'(1);
    end else begin
      // A silent line forgets any earlier run, so a stale count cannot revive the link.
      next_run = '0;
    end
    case (state)
      PHYGS_GOOD: begin
        if (gap > CW'(FAIL_N)) begin
          next_state = PHYGS_FAIL;  // see R12
        end
      end
      PHYGS_FAIL: begin
        if (!neg_enable_i && run == RW'(RUN_N)) begin
          next_state = PHYGS_GOOD;  // see R13
        // Negotiation only revives a line that has carried a recent pulse.
        end else if (neg_enable_i && neg_done_i && (gap <= CW'(FAIL_N))) begin
          next_state = PHYGS_GOOD;
        end
      end
      default: next_state = PHYGS_FAIL;
    endcase
  end

  // Only sync[1] reads the first stage; edges are found after the second.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sync  <= 3'h0;
      gap   <= '0;
      run   <= '0;
      state <= PHYGS_GOOD;
    end else begin
      sync  <= {sync[1:0], pulse_pin_i};
      gap   <= next_gap;
      run   <= next_run;
      state <= next_state;
    end
  end

  assign link_ok_o = (state == PHYGS_GOOD);

  a_silence_fails: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R12
    (gap > CW'(FAIL_N)) |=> !link_ok_o) else $error("Link kept after pulse silence.");

  a_bad_gap_run: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R11
    (edge_seen && !gap_good) |=> (run == '0)) else $error("Mistimed pulse kept the run.");

  a_silence_run_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R13
    (gap > CW'(FAIL_N)) |=> (run == '0)) else $error("Run kept across silence.");

endmodule

//--- rtl/phygs_status.sv
`timescale 1ns/100ps
// Functional notes
// R1: Bits 14..11 read constant one.
// R2: Reserved bits 10..7 read zero.
// R3: Bit 6 one; preamble-less frames accepted.
// R4: Completion flag one only after negotiation finishes.
// R5: Completion zero if running, restarting, or disabled.
// R6: Protocol error restart sets remote fault.
// R7: Remote fault means reload first next page.
// R8: Remote fault resets zero, held until read.
// R9: Bit 3 reads constant one.
// R10: Link flag resets one, change held until read.
// R11: Link pulses 8 to 24 ms apart.
// R12: Over 100 ms silence clears link.
// R13: Negotiation off: timed pulse run restores link.
// R14: 100M link needs 330 us descrambler lock.
// R15: Link loss with negotiation on restarts it.
// R16: Jabber flag reads zero at 100M.
// R17: 10M jabber latches until read or reset.
// R18: Seven good pulses restore the link.
// R19: Read returns held value, then tracks condition.
module phygs_status
  import phygs_pkg::*;
#(
  parameter int unsigned MIN_N  = GAP_MIN_CYC,
  parameter int unsigned MAX_N  = GAP_MAX_CYC,
  parameter int unsigned FAIL_N = FAIL_CYC,
  parameter int unsigned LOCK_N = LOCK_CYC,
  parameter int unsigned RUN_N  = RUN_LEN
) (
  input  wire logic        sys_clk_i,        // Device clock, 50 MHz.
  input  wire logic        nrst_i,           // Synchronous reset, active low.
  input  wire logic        status_rd_i,      // One-cycle read strobe of the status word.
  output logic [15:0]      status_rdata_o,   // Status word captured by the read.
  output logic             pre_optional_o,   // Management frames may skip preamble.
  input  wire logic        speed_100_i,      // High in 100 Mbit/s mode.
  input  wire phygs_neg_t  neg_i,            // Negotiation engine and control signals.
  input  wire logic        link_pulse_i,     // Received link pulse, asynchronous pin.
  input  wire logic        descr_lock_i,     // Descrambler locked.
  input  wire logic        jabber_i,         // Jabber condition seen at 10 Mbit/s.
  output logic             neg_restart_req_o // Pulse asking negotiation to restart.
);

  logic        pulse_ok;
  logic        lock_ok;
  logic        link_now;
  logic        link_now_q;
  logic        link_lat;
  logic        link_hold;
  logic        remote_fault_flag;
  logic        jabber;
  logic        cmplt_now;
  logic [15:0] rdata;
  logic        next_link_lat;
  logic        next_link_hold;
  logic        next_remote_fault_flag;
  logic        next_jabber;
  logic [15:0] next_rdata;

  phygs_pulse_mon #(
    .MIN_N  (MIN_N),
    .MAX_N  (MAX_N),
    .FAIL_N (FAIL_N),
    .RUN_N  (RUN_N)
  ) u_pulse (
    .sys_clk_i    (sys_clk_i),
    .nrst_i       (nrst_i),
    .pulse_pin_i  (link_pulse_i),
    .neg_enable_i (neg_i.enable),
    .neg_done_i   (neg_i.done),
    .link_ok_o    (pulse_ok)
  );

  phygs_lock_qual #(
    .LOCK_N (LOCK_N)
  ) u_lock (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .lock_i    (descr_lock_i),
    .lock_ok_o (lock_ok)
  );

  assign link_now  = speed_100_i ? lock_ok : pulse_ok;                 // see R14
  assign cmplt_now = neg_i.enable & ~neg_i.restart & neg_i.done;       // see R4
  assign pre_optional_o = 1'b1;                                        // see R3

  // A falling link restarts negotiation while it is switched on.
  assign neg_restart_req_o = neg_i.enable & link_now_q & ~link_now;    // see R15

  always_comb begin
    next_link_lat  = link_lat;
    next_link_hold = link_hold;
    next_remote_fault_flag    = remote_fault_flag;
    next_jabber    = jabber;
    next_rdata     = rdata;
    // The read returns the held state and releases it to follow again.
    if (status_rd_i) begin
      next_rdata                              = STATUS_RESET;           // see R1
      next_rdata[BIT_RSVD_HI:BIT_RSVD_LO]     = 4'h0;                   // see R2
      next_rdata[BIT_PRE_SUPP]                = 1'b1;                   // see R3
      next_rdata[BIT_NEG_CMPLT]               = cmplt_now;              // see R5
      next_rdata[BIT_REMOTE_FAULT_FLAG]                  = remote_fault_flag;                 // see R7
      next_rdata[BIT_NEG_ABIL]                = 1'b1;                   // see R9
      next_rdata[BIT_LINK]                    = link_lat;               // see R19
      next_rdata[BIT_JABBER]                  = jabber & ~speed_100_i;  // see R16
      next_link_lat  = link_now;
      next_link_hold = 1'b0;
      next_remote_fault_flag    = 1'b0;
      next_jabber    = 1'b0;
    end else if (!link_hold) begin
      next_link_lat  = link_now;
      next_link_hold = (link_now != link_lat);                          // see R10
    end
    // A new event in the read cycle wins over the release.
    if (neg_i.err_restart) begin
      next_remote_fault_flag = 1'b1;                                               // see R6
    end
    if (jabber_i && !speed_100_i) begin
      next_jabber = 1'b1;                                               // see R17
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      link_lat   <= LINK_RESET;                                         // see R10
      link_hold  <= 1'b0;
      link_now_q <= LINK_RESET;
      remote_fault_flag     <= REMOTE_FAULT_FLAG_RESET;                                       // see R8
      jabber     <= JABBER_RESET;
      rdata      <= STATUS_RESET;
    end else begin
      link_lat   <= next_link_lat;
      link_hold  <= next_link_hold;
      link_now_q <= link_now;
      remote_fault_flag     <= next_remote_fault_flag;
      jabber     <= next_jabber;
      rdata      <= next_rdata;
    end
  end

  assign status_rdata_o = rdata;

  sequence s_read;
    status_rd_i;
  endsequence

  sequence s_fault_pending;
    remote_fault_flag && !status_rd_i;
  endsequence

  a_const_bits: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R1
    s_read |=> (status_rdata_o[15:11] == 5'b01111 && status_rdata_o[BIT_NEG_ABIL]))
    else $error("Ability bits wrong.");

  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R2
    s_read |=> (status_rdata_o[BIT_RSVD_HI:BIT_RSVD_LO] == 4'h0
                && status_rdata_o[0] == 1'b0 && status_rdata_o[BIT_PRE_SUPP]))
    else $error("Reserved or preamble bit wrong.");

  a_cmplt_gated: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R5
    (status_rd_i && (!neg_i.enable || neg_i.restart || !neg_i.done))
      |=> !status_rdata_o[BIT_NEG_CMPLT]) else $error("Completion shown too early.");

  a_remote_fault_flag_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R8
    s_fault_pending |=> remote_fault_flag) else $error("Remote fault lost.");

  a_remote_fault_flag_set: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R6
    neg_i.err_restart |=> remote_fault_flag) else $error("Remote fault not set.");

  a_remote_fault_flag_shown: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R19
    (s_read ##0 remote_fault_flag) |=> status_rdata_o[BIT_REMOTE_FAULT_FLAG]) else $error("Remote fault not read.");

  a_jabber_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R17
    (jabber && !status_rd_i) |=> jabber) else $error("Jabber flag lost.");

  a_jabber_100: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R16
    (status_rd_i && speed_100_i) |=> !status_rdata_o[BIT_JABBER])
    else $error("Jabber shown at 100M.");

  a_link_drop_kept: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R10
    (!status_rd_i && !link_hold && link_lat && !link_now) |=> (link_hold && !link_lat)
      ##0 (!status_rd_i)[*1] |=> !link_lat) else $error("Link drop not held.");

  a_restart_req: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R15
    ($fell(link_now) && neg_i.enable) |-> neg_restart_req_o)
    else $error("No restart on link loss.");

  a_read_releases: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see R19
    (status_rd_i && !neg_i.err_restart) |=> (!remote_fault_flag && link_lat == $past(link_now)))
    else $error("Read did not release flags.");

endmodule

//--- tb/phygs_pulse_src.sv
`timescale 1ns/100ps
module phygs_pulse_src (
  output logic pulse_o  // Link pulse towards the device pin.
);
  logic lclk;
  initial begin
    pulse_o = 1'b0;
    lclk    = 1'b0;
  end
  // The link clock runs only inside a burst, so the pin rests low between bursts.
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      for (int t = 0; t < gap; t++) begin
        #80 lclk = 1'b1;
        pulse_o = (t == 0);
        #80 lclk = 1'b0;
      end
    end
    pulse_o = 1'b0;
  endtask
endmodule

//--- tb/phygs_status_test.sv
`timescale 1ns/100ps
module phygs_status_test;
  import phygs_pkg::*;
  logic        clk;
  logic        nrst;
  logic        rd;
  logic [15:0] rdata;
  logic        pre_opt;
  logic        speed_100;
  phygs_neg_t  neg;
  logic        pulse;
  logic        lock;
  logic        jabber;
  logic        restart_req;
  logic [15:0] w;
  int          err_count;
  int          num_checks;

  phygs_status #(.MIN_N(8), .MAX_N(24), .FAIL_N(100), .LOCK_N(33), .RUN_N(7)) dut (
    .sys_clk_i(clk), .nrst_i(nrst), .status_rd_i(rd), .status_rdata_o(rdata),
    .pre_optional_o(pre_opt), .speed_100_i(speed_100), .neg_i(neg),
    .link_pulse_i(pulse), .descr_lock_i(lock), .jabber_i(jabber),
    .neg_restart_req_o(restart_req));
  phygs_pulse_src src (.pulse_o(pulse));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_word(output logic [15:0] v);
    @(negedge clk) rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    v = rdata;
  endtask

  task automatic test_const();
    rd_word(w);
    chk("word", 16'h784C, w);
    chk("preamble", 16'h0001, 16'(pre_opt));
  endtask

  task automatic test_remote_fault_flag();
    @(negedge clk) neg.err_restart = 1'b1;
    @(negedge clk) neg.err_restart = 1'b0;
    repeat (3) @(negedge clk);
    rd_word(w);
    chk("remote_fault_flag held", 16'h0001, 16'(w[BIT_REMOTE_FAULT_FLAG]));
    rd_word(w);
    chk("remote_fault_flag released", 16'h0000, 16'(w[BIT_REMOTE_FAULT_FLAG]));
  endtask

  task automatic test_jabber();
    @(negedge clk) jabber = 1'b1;
    @(negedge clk) jabber = 1'b0;
    repeat (3) @(negedge clk);
    rd_word(w);
    chk("jabber held", 16'(!speed_100), 16'(w[BIT_JABBER]));
    rd_word(w);
    chk("jabber released", 16'h0000, 16'(w[BIT_JABBER]));
  endtask

  // Every enable, restart and done combination; only enabled, done, not restarting reads one.
  task automatic test_cmplt();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) neg = phygs_neg_t'({i[2:0], 1'b0});
      rd_word(w);
      chk("complete", 16'(i == 5), 16'(w[BIT_NEG_CMPLT]));
    end
  endtask

  task automatic test_link10();
    bit hit;
    hit = 1'b0;
    @(negedge clk) neg = phygs_neg_t'(4'b1010);
    repeat (5) @(negedge clk);
    neg = phygs_neg_t'(4'b1000);
    rd_word(w);
    rd_word(w);
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      if (restart_req === 1'b1) hit = 1'b1;
    end
    chk("restart request", 16'h0001, 16'(hit));
    rd_word(w);
    chk("link failed", 16'h0000, 16'(w[BIT_LINK]));
    neg = phygs_neg_t'(4'b0000);
    src.burst(8, 4);
    rd_word(w);
    chk("slow pulses", 16'h0000, 16'(w[BIT_LINK]));
    src.burst(8, 2);
    repeat (5) @(negedge clk);
    rd_word(w);
    chk("link restored", 16'h0001, 16'(w[BIT_LINK]));
  endtask

  // With negotiation on, its completion restores a link that carries pulses again.
  task automatic test_neg_done();
    @(negedge clk) neg = phygs_neg_t'(4'b1000);
    repeat (150) @(negedge clk);
    rd_word(w);
    chk("neg link lost", 16'h0000, 16'(w[BIT_LINK]));
    neg = phygs_neg_t'(4'b1010);
    src.burst(1, 2);
    repeat (5) @(negedge clk);
    rd_word(w);
    chk("neg link back", 16'h0001, 16'(w[BIT_LINK]));
    neg = phygs_neg_t'(4'b0000);
  endtask

  task automatic test_lock100();
    @(negedge clk) speed_100 = 1'b1;
    rd_word(w);
    rd_word(w);
    chk("no lock", 16'h0000, 16'(w[BIT_LINK]));
    lock = 1'b1;
    repeat (20) @(negedge clk);
    lock = 1'b0;
    rd_word(w);
    chk("short lock", 16'h0000, 16'(w[BIT_LINK]));
    lock = 1'b1;
    repeat (40) @(negedge clk);
    rd_word(w);
    chk("long lock", 16'h0001, 16'(w[BIT_LINK]));
    test_jabber();
  endtask

  initial begin
    err_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    rd = 1'b0;
    speed_100 = 1'b0;
    neg = phygs_neg_t'(4'b0000);
    lock = 1'b0;
    jabber = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    test_const();
    test_remote_fault_flag();
    test_jabber();
    test_cmplt();
    test_link10();
    test_neg_done();
    test_lock100();
    test_done();
  end

  // The whole sequence needs about 18 microseconds; this leaves a wide margin.
  initial begin
    #400_000;
    err_count++;
    test_done();
  end
endmodule
